//--- core/irp_ctrl.sv
// Purpose: Group 2 request register, group 0/1 level enables, pin edges
// Assumes: Group 0/1 request bits and group 2 enables live outside
// Notes:   Register reads return data one cycle after the read strobe
//          Map: fc1/fc2 group 0 high/low enables, fc4/fc5 group 1,
//          fc6 group 2 pending, fcd edge select, fce shared select,
//          fd0 event status (a read clears it), fd1 event mask
//          A pin change shows in its pending bit three edges later:
//          two synchroniser flops and one edge compare
//          Group 0/1 request bits and group 2 enables are inputs, so
//          only the levels that they give are judged here
//          A pin held high through reset reads as a rising edge after
//          release; port A is safe since falling select is the default
//          Switching a shared source may raise a request; disable first
`timescale 1ns/1ps
`default_nettype none
module irp_ctrl
  import irp_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Register bus
  input  wire irp_bus_s   reg_bus,
  output logic [7:0]      rd_data,
  // Pins and detectors, asynchronous
  input  wire logic [7:0] porta_pin,
  input  wire logic [3:0] portc_pin_request,
  input  wire logic       low_voltage_detector,
  input  wire logic       comparator_out,
  // Core side, same clock
  input  wire logic       global_irq_en,
  input  wire logic [7:0] group0_request_pending,
  input  wire logic [7:0] group1_request_pending,
  input  wire logic [3:0] group2_en_hi,
  input  wire logic [3:0] group2_en_lo,
  // Requests out
  output logic [7:0]      porta_req_pulse,
  output logic            core_irq_req,
  output logic [1:0]      core_irq_level,
  // Event interrupt
  output logic            irq
);

  irp_state_s st_r;
  irp_state_s st_nxt;

  logic [IRP_SYNC_W-1:0] synced;
  logic [7:0]            pa_s;
  logic [3:0]            pc_s;
  logic                  lvd_s;
  logic                  cmp_s;
  logic [7:0]            pa_src;
  logic [11:0]           cur;
  logic [7:0]            pa_rise;
  logic [7:0]            pa_fall;
  logic [7:0]            pa_ev;
  logic [3:0]            pc_ev;
  logic [4:0]            new_ev;
  logic                  any_req;
  logic [1:0]            top_lvl;
  logic                  wr_hit;
  logic                  rd_stat;

  // Every pin and detector level crosses two flops before any logic sees it
  irp_sync u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .raw     ({comparator_out, low_voltage_detector,
                portc_pin_request, porta_pin}),
    .synced  (synced)
  );

  assign pa_s  = synced[7:0];
  assign pc_s  = synced[11:8];
  assign lvd_s = synced[12];
  assign cmp_s = synced[13];

  // Shared sources: the select picks pin or detector, not the enables
  always_comb begin
    pa_src = pa_s;
    if (st_r.share_sel[1]) pa_src[IRP_B_PIN7_LVD] = lvd_s;
    if (st_r.share_sel[0]) pa_src[IRP_B_PIN6_CMP] = cmp_s;
  end

  // Switching a shared source can itself look like an edge;
  // software must disable the request before switching.
  assign cur     = {pc_s, pa_src};
  assign pa_rise = cur[7:0] & ~st_r.prev[7:0];
  assign pa_fall = ~cur[7:0] & st_r.prev[7:0];

  // Edge select per pin: zero falling, one rising
  assign pa_ev = (st_r.edge_sel & pa_rise) | (~st_r.edge_sel & pa_fall);

  // Port C requests are taken on the rising edge of the pin
  assign pc_ev = cur[11:8] & ~st_r.prev[11:8];

  // Events that reach the sticky status register
  assign new_ev = {|pa_ev, pc_ev};

  // Highest enabled pending level across all three groups
  irp_prio u_prio (
    .g0_pend (group0_request_pending),
    .g0_hi   (st_r.g0_hi),
    .g0_lo   (st_r.g0_lo),
    .g1_pend (group1_request_pending),
    .g1_hi   (st_r.g1_hi),
    .g1_lo   (st_r.g1_lo),
    .g2_pend (st_r.g2_pend),
    .g2_hi   (group2_en_hi),
    .g2_lo   (group2_en_lo),
    .any_req (any_req),
    .top_lvl (top_lvl)
  );

  assign wr_hit  = reg_bus.wr;
  assign rd_stat = reg_bus.rd && (reg_bus.addr == IRP_A_STAT);

  // Register file, pending bits, status and read data
  always_comb begin
    st_nxt          = st_r;
    st_nxt.prev     = cur;
    st_nxt.pa_pulse = pa_ev;

    // Writes: reserved bits are dropped so they read back as zero; group 0 high stores all eight bits
    if (wr_hit) begin
      unique case (reg_bus.addr)
        IRP_A_G0_HI:  st_nxt.g0_hi = reg_bus.wdata;
        IRP_A_G0_LO:  st_nxt.g0_lo = reg_bus.wdata & IRP_G0_WMASK;
        IRP_A_G1_HI:  st_nxt.g1_hi = reg_bus.wdata;
        IRP_A_G1_LO:  st_nxt.g1_lo = reg_bus.wdata;
        IRP_A_G2_REQ: st_nxt.g2_pend = reg_bus.wdata[3:0];
        IRP_A_EDGE:   st_nxt.edge_sel = reg_bus.wdata;
        IRP_A_SHARE:  st_nxt.share_sel = reg_bus.wdata[7:6];
        IRP_A_MASK:   st_nxt.mask = reg_bus.wdata[4:0];
        default:      st_nxt.g0_hi = st_r.g0_hi;
      endcase
    end

    // A pin request in the same cycle as a write still lands
    st_nxt.g2_pend = st_nxt.g2_pend | pc_ev;

    // Sticky events: read clears, but a new event wins over the clear
    st_nxt.stat = (rd_stat ? 5'h00 : st_r.stat) | new_ev;

    // Forward only while globally enabled; otherwise software polls
    st_nxt.core_req = global_irq_en && any_req;
    st_nxt.core_lvl = global_irq_en ? top_lvl : IRP_LVL_OFF;

    // Read data stand only in the cycle after the strobe
    st_nxt.rd_data = IRP_RST_BYTE;
    if (reg_bus.rd) begin
      unique case (reg_bus.addr)
        IRP_A_G0_HI:  st_nxt.rd_data = st_r.g0_hi;
        IRP_A_G0_LO:  st_nxt.rd_data = st_r.g0_lo;
        IRP_A_G1_HI:  st_nxt.rd_data = st_r.g1_hi;
        IRP_A_G1_LO:  st_nxt.rd_data = st_r.g1_lo;
        IRP_A_G2_REQ: st_nxt.rd_data = {4'h0, st_r.g2_pend};
        IRP_A_EDGE:   st_nxt.rd_data = st_r.edge_sel;
        IRP_A_SHARE:  st_nxt.rd_data = {st_r.share_sel, 6'h00};
        IRP_A_STAT:   st_nxt.rd_data = {3'h0, st_r.stat};
        IRP_A_MASK:   st_nxt.rd_data = {3'h0, st_r.mask};
        default:      st_nxt.rd_data = IRP_RST_BYTE;
      endcase
    end
  end

  // State register; reset clears everything
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= IRP_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs all come from flops except the level interrupt
  assign rd_data         = st_r.rd_data;
  assign porta_req_pulse = st_r.pa_pulse;
  assign core_irq_req    = st_r.core_req;
  assign core_irq_level  = st_r.core_lvl;
  assign irq             = |(st_r.stat & st_r.mask);

  // ---------------- Checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_portc_sets_pend: assert property (
    (|pc_ev) |=> ((st_r.g2_pend & $past(pc_ev)) == $past(pc_ev)))
    else $error("Port C request did not set its pending bit");

  a_forward_enabled: assert property (
    (global_irq_en && any_req) |=> (core_irq_req && core_irq_level == $past(top_lvl)))
    else $error("Enabled pending request not forwarded");

  a_poll_disabled: assert property (
    !global_irq_en |=> (!core_irq_req && core_irq_level == IRP_LVL_OFF))
    else $error("Request forwarded while globally disabled");

  a_pend_readback: assert property (
    (reg_bus.rd && reg_bus.addr == IRP_A_G2_REQ)
      |=> (rd_data == {4'h0, $past(st_r.g2_pend)}))
    else $error("Group 2 read data wrong");

  a_g0_lo_reserved: assert property (
    (reg_bus.wr && reg_bus.addr == IRP_A_G0_LO)
      |=> (st_r.g0_lo == ($past(reg_bus.wdata) & IRP_G0_WMASK)))
    else $error("Group 0 low reserved bits stored");

  a_edge_select: assert property (
    (st_r.prev[0] && !cur[0] && !st_r.edge_sel[0]) |=> porta_req_pulse[0])
    else $error("Falling edge not taken with select zero");

  a_share_source: assert property (
    st_r.share_sel[1] |-> (pa_src[IRP_B_PIN7_LVD] == lvd_s))
    else $error("Shared source not taken from detector");

  a_level_nonzero: assert property (
    core_irq_req |-> (core_irq_level != IRP_LVL_OFF))
    else $error("Request forwarded with level off");

  a_reset_clear: assert property (
    @(posedge clock) disable iff (1'b0)
    sys_rst |=> (st_r.g0_hi == 8'h00 && st_r.g1_lo == 8'h00 && st_r.g2_pend == 4'h0 && !core_irq_req))
    else $error("Registers not cleared by reset");

  a_irq_level: assert property (
    (|(st_r.stat & st_r.mask)) |-> irq)
    else $error("Unmasked status did not raise interrupt");

  // Group 0 high and group 1 enable registers keep what software wrote
  a_g0_hi_store: assert property (
    (reg_bus.wr && reg_bus.addr == IRP_A_G0_HI)
      |=> (st_r.g0_hi == $past(reg_bus.wdata)))
    else $error("Group 0 high enable not stored");

  a_g0_hi_readback: assert property (
    (reg_bus.rd && reg_bus.addr == IRP_A_G0_HI)
      |=> (rd_data == $past(st_r.g0_hi)))
    else $error("Group 0 high enable read data wrong");

  a_g1_hi_store: assert property (
    (reg_bus.wr && reg_bus.addr == IRP_A_G1_HI)
      |=> (st_r.g1_hi == $past(reg_bus.wdata)))
    else $error("Group 1 high enable not stored");

  a_g1_lo_store: assert property (
    (reg_bus.wr && reg_bus.addr == IRP_A_G1_LO)
      |=> (st_r.g1_lo == $past(reg_bus.wdata)))
    else $error("Group 1 low enable not stored");

  // Pending bits change only by a write or a pin request
  a_g2_write: assert property (
    (reg_bus.wr && reg_bus.addr == IRP_A_G2_REQ)
      |=> (st_r.g2_pend == ($past(reg_bus.wdata[3:0]) | $past(pc_ev))))
    else $error("Group 2 write not stored");

  a_g2_hold: assert property (
    (!(reg_bus.wr && reg_bus.addr == IRP_A_G2_REQ) && !(|pc_ev))
      |=> $stable(st_r.g2_pend))
    else $error("Group 2 pending bits changed by themselves");

  // While globally enabled, the forwarded level is never below that of an enabled pending source
  a_timer1_level: assert property (
    (global_irq_en && group0_request_pending[IRP_B_TIMER1])
      |=> (core_irq_level >= $past(irp_level(st_r.g0_hi[IRP_B_TIMER1], st_r.g0_lo[IRP_B_TIMER1]))))
    else $error("Timer one level lost");

  a_timer0_level: assert property (
    (global_irq_en && group0_request_pending[IRP_B_TIMER0])
      |=> (core_irq_level >= $past(irp_level(st_r.g0_hi[IRP_B_TIMER0], st_r.g0_lo[IRP_B_TIMER0]))))
    else $error("Timer zero level lost");

  a_rx_level: assert property (
    (global_irq_en && group0_request_pending[IRP_B_RX])
      |=> (core_irq_level >= $past(irp_level(st_r.g0_hi[IRP_B_RX], st_r.g0_lo[IRP_B_RX]))))
    else $error("Serial receive level lost");

  a_tx_level: assert property (
    (global_irq_en && group0_request_pending[IRP_B_TX])
      |=> (core_irq_level >= $past(irp_level(st_r.g0_hi[IRP_B_TX], st_r.g0_lo[IRP_B_TX]))))
    else $error("Serial transmit level lost");

  a_conv_level: assert property (
    (global_irq_en && group0_request_pending[IRP_B_CONV])
      |=> (core_irq_level >= $past(irp_level(st_r.g0_hi[IRP_B_CONV], st_r.g0_lo[IRP_B_CONV]))))
    else $error("Converter level lost");

  a_pin7_level: assert property (
    (global_irq_en && group1_request_pending[IRP_B_PIN7_LVD])
      |=> (core_irq_level >= $past(irp_level(st_r.g1_hi[IRP_B_PIN7_LVD], st_r.g1_lo[IRP_B_PIN7_LVD]))))
    else $error("Pin 7 or voltage detect level lost");

  a_pin6_level: assert property (
    (global_irq_en && group1_request_pending[IRP_B_PIN6_CMP])
      |=> (core_irq_level >= $past(irp_level(st_r.g1_hi[IRP_B_PIN6_CMP], st_r.g1_lo[IRP_B_PIN6_CMP]))))
    else $error("Pin 6 or comparator level lost");

  // Rising select takes rising edges and nothing else
  a_rise_taken: assert property (
    (!st_r.prev[1] && cur[1] && st_r.edge_sel[1]) |=> porta_req_pulse[1])
    else $error("Rising edge not taken with select one");

  a_fall_ignored: assert property (
    (st_r.prev[1] && !cur[1] && st_r.edge_sel[1]) |=> !porta_req_pulse[1])
    else $error("Falling edge taken with select one");

  a_cmp_source: assert property (
    st_r.share_sel[0] |-> (pa_src[IRP_B_PIN6_CMP] == cmp_s))
    else $error("Shared source not taken from comparator");

  a_pin_source: assert property (
    !st_r.share_sel[1] |-> (pa_src[IRP_B_PIN7_LVD] == pa_s[IRP_B_PIN7_LVD]))
    else $error("Pin 7 request not taken from its pin");

  // Status stays until read; a read with no new event empties it
  a_stat_sticky: assert property (
    (!rd_stat && new_ev == 5'h00) |=> $stable(st_r.stat))
    else $error("Status changed with no event and no read");

  a_stat_read_clear: assert property (
    (rd_stat && new_ev == 5'h00) |=> (st_r.stat == 5'h00))
    else $error("Status read did not clear");

  a_porta_status: assert property (
    (|pa_ev) |=> st_r.stat[IRP_B_ST_PA])
    else $error("Port A event not in status");

  a_rd_idle: assert property (
    !reg_bus.rd |=> (rd_data == IRP_RST_BYTE))
    else $error("Read data stood without a read strobe");

  a_reset_outputs: assert property (
    @(posedge clock) disable iff (1'b0)
    sys_rst |=> (rd_data == 8'h00 && porta_req_pulse == 8'h00 && !irq && core_irq_level == IRP_LVL_OFF))
    else $error("Outputs not cleared by reset");

  c_portc_pend: cover property ((|pc_ev) ##1 core_irq_req);
  c_poll_read: cover property (!global_irq_en && reg_bus.rd && reg_bus.addr == IRP_A_G2_REQ);
  c_high_level: cover property (core_irq_level == IRP_LVL_HIGH);
  c_stat_clear: cover property (irq ##1 rd_stat ##1 !irq);
  c_rise_event: cover property (st_r.edge_sel[1] && pa_rise[1]);

endmodule
`default_nettype wire

//--- core/irp_pkg.sv
// Function
// - A port C pin request sets its pending bit in the group 2 register.
// - With global enable on, enabled pending requests go to the core.
// - With global enable off, pending bits stay readable for polling.
// - Group 2 bits 3..0 show port C pin requests; one means pending.
// - Group 0 high/low bits form a level: off, low, medium, high.
// - Group 1 uses the same two-bit high/low level code.
// - Group 0 bits: 6 timer one, 5 timer zero, 4 rx, 3 tx, 0 converter.
// - Group 1 bit 7 pin7/voltage detect, bit 6 pin6/comparator, 5..0 pins.
// - Shared group 1 sources are picked by the shared source select.
// - Port A edge select zero means falling edge, one rising edge.
//
// Purpose: Shared constants and carriers of the interrupt request block
// Assumes: 8-bit register bus, 12-bit register addresses
// Notes:   Register reset values are all zero
package irp_pkg;

  // Register addresses
  localparam logic [11:0] IRP_A_G0_HI  = 12'hfc1;
  localparam logic [11:0] IRP_A_G0_LO  = 12'hfc2;
  localparam logic [11:0] IRP_A_G1_HI  = 12'hfc4;
  localparam logic [11:0] IRP_A_G1_LO  = 12'hfc5;
  localparam logic [11:0] IRP_A_G2_REQ = 12'hfc6;
  localparam logic [11:0] IRP_A_EDGE   = 12'hfcd;
  localparam logic [11:0] IRP_A_SHARE  = 12'hfce;
  localparam logic [11:0] IRP_A_STAT   = 12'hfd0;
  localparam logic [11:0] IRP_A_MASK   = 12'hfd1;

  // Writable bits per register
  localparam logic [7:0]  IRP_G0_WMASK    = 8'h79;
  localparam logic [7:0]  IRP_G2_WMASK    = 8'h0f;
  localparam logic [7:0]  IRP_SHARE_WMASK = 8'hc0;
  localparam logic [7:0]  IRP_STAT_WMASK  = 8'h1f;
  localparam logic [7:0]  IRP_RST_BYTE    = 8'h00;

  // Group 0 field positions
  localparam int IRP_B_TIMER1 = 6;
  localparam int IRP_B_TIMER0 = 5;
  localparam int IRP_B_RX     = 4;
  localparam int IRP_B_TX     = 3;
  localparam int IRP_B_CONV   = 0;

  // Group 1 shared positions and status bit of port A events
  localparam int IRP_B_PIN7_LVD = 7;
  localparam int IRP_B_PIN6_CMP = 6;
  localparam int IRP_B_ST_PA    = 4;

  // Synchroniser width: {comparator, lvd, port C[3:0], port A[7:0]}
  localparam int IRP_SYNC_W = 14;

  // Priority levels
  typedef enum logic [1:0] {
    IRP_LVL_OFF  = 2'b00,
    IRP_LVL_LOW  = 2'b01,
    IRP_LVL_MED  = 2'b10,
    IRP_LVL_HIGH = 2'b11
  } irp_level_e;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } irp_bus_s;

  // Synchroniser state
  typedef struct packed {
    logic [IRP_SYNC_W-1:0] meta;
    logic [IRP_SYNC_W-1:0] stab;
  } irp_sync_s;

  // Controller state
  typedef struct packed {
    logic [7:0] g0_hi;
    logic [7:0] g0_lo;
    logic [7:0] g1_hi;
    logic [7:0] g1_lo;
    logic [3:0] g2_pend;
    logic [7:0] edge_sel;
    logic [1:0] share_sel;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [11:0] prev;
    logic [7:0] pa_pulse;
    logic       core_req;
    logic [1:0] core_lvl;
    logic [7:0] rd_data;
  } irp_state_s;

  localparam irp_state_s IRP_STATE_RST = '0;

  // Level of one request from its high and low enable bits
  function automatic irp_level_e irp_level(input logic hi, input logic lo);
    return irp_level_e'({hi, lo});
  endfunction

endpackage

//--- core/irp_prio.sv
// Purpose: Finds the highest level among enabled pending requests
// Assumes: Pending and enable bits from the same clock
// Notes:   Purely combinational, no state
`timescale 1ns/1ps
`default_nettype none
module irp_prio
  import irp_pkg::*;
(
  // Group 0 and group 1 pending and enables
  input  wire logic [7:0] g0_pend,
  input  wire logic [7:0] g0_hi,
  input  wire logic [7:0] g0_lo,
  input  wire logic [7:0] g1_pend,
  input  wire logic [7:0] g1_hi,
  input  wire logic [7:0] g1_lo,
  // Group 2 pending and enables
  input  wire logic [3:0] g2_pend,
  input  wire logic [3:0] g2_hi,
  input  wire logic [3:0] g2_lo,
  // Result
  output logic            any_req,
  output logic [1:0]      top_lvl
);

  // Scan all requests; disabled ones have level zero and never win
  always_comb begin
    logic [1:0] l;
    l = IRP_LVL_OFF;
    for (int i = 0; i < 8; i++) begin
      if (g0_pend[i] && irp_level(g0_hi[i], g0_lo[i]) > l) l = irp_level(g0_hi[i], g0_lo[i]);
      if (g1_pend[i] && irp_level(g1_hi[i], g1_lo[i]) > l) l = irp_level(g1_hi[i], g1_lo[i]);
    end
    for (int i = 0; i < 4; i++) begin
      if (g2_pend[i] && irp_level(g2_hi[i], g2_lo[i]) > l) l = irp_level(g2_hi[i], g2_lo[i]);
    end
    top_lvl = l;
    any_req = (l != IRP_LVL_OFF);
  end

endmodule
`default_nettype wire

//--- core/irp_sync.sv
// Purpose: Two-flop synchroniser for pins and analog detector outputs
// Assumes: Inputs are asynchronous to clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module irp_sync
  import irp_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // Raw and synchronised levels
  input  wire logic [IRP_SYNC_W-1:0] raw,
  output logic      [IRP_SYNC_W-1:0] synced
);

  irp_sync_s q_r;
  irp_sync_s q_nxt;

  // Next stage values
  always_comb begin
    q_nxt      = q_r;
    q_nxt.meta = raw;
    q_nxt.stab = q_r.meta;
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign synced = q_r.stab;

endmodule
`default_nettype wire

//--- sim/irp_core_model.sv
// Purpose: Far side model: group 1 request register fed by port A events
// Assumes: Event pulses last one cycle
// Notes:   A pulse in the cycle of a clear is dropped, which the bench avoids
`timescale 1ns/1ps
`default_nettype none
module irp_core_model
  import irp_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Events in, sticky request bits out
  input  wire logic [7:0] porta_req_pulse,
  input  wire logic       clr,
  output logic      [7:0] g1_pend
);
  // Requests stay until the bench clears them, like a real request register
  always_ff @(posedge clock) begin
    if (sys_rst || clr) begin
      g1_pend <= 8'h00;
    end else begin
      g1_pend <= g1_pend | porta_req_pulse;
    end
  end
endmodule
`default_nettype wire

//--- sim/irq_request_priority_enable_bench.sv
// Purpose: Self-checking bench of the interrupt request block
// Assumes: Read data stands only in the cycle after the strobe
// Notes:   Port A events are caught by the core model
`timescale 1ns/1ps
`default_nettype none
module irq_request_priority_enable_bench
  import irp_pkg::*;
;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       gie = 1'b0;
  logic       g1_clr = 1'b0;
  irp_bus_s   bus = '0;
  logic [7:0] pa = 8'hff;
  logic [7:0] g0p = 8'h00;
  logic [3:0] pc = 4'h0;
  logic [3:0] g2h = 4'h0;
  logic [3:0] g2l = 4'h0;
  logic [7:0] rdd, pulse, g1p;
  logic       req, irq;
  logic [1:0] lvl;
  int         failures = 0;
  int         total_checks = 0;
  int         cycles = 0;
  logic [11:0] regs [5] = '{IRP_A_G0_HI, IRP_A_G0_LO, IRP_A_G1_HI, IRP_A_G1_LO, IRP_A_G2_REQ};

  irp_ctrl uut (.clock(clock), .sys_rst(sys_rst), .reg_bus(bus), .rd_data(rdd), .porta_pin(pa),
    .portc_pin_request(pc), .low_voltage_detector(1'b0), .comparator_out(1'b0), .global_irq_en(gie),
    .group0_request_pending(g0p), .group1_request_pending(g1p), .group2_en_hi(g2h),
    .group2_en_lo(g2l), .porta_req_pulse(pulse), .core_irq_req(req), .core_irq_level(lvl), .irq(irq));

  irp_core_model core (.clock(clock), .sys_rst(sys_rst), .porta_req_pulse(pulse), .clr(g1_clr),
    .g1_pend(g1p));

  // 25 MHz clock
  always #20 clock = ~clock;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Strobe dropped for a cycle after each access, so no signal is set twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 chk(rdd, exp, "read data");
    @(posedge clock);
  endtask

  task automatic t_reset;
    chk({4'h0, req, lvl, irq}, 8'h00, "outputs after reset");
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    rdchk(12'h100, 8'h00);
    $display("Test reset values done");
  endtask

  task automatic t_regs;
    wr(IRP_A_G0_HI, 8'h79);
    rdchk(IRP_A_G0_HI, 8'h79);
    wr(IRP_A_G0_LO, 8'h79);
    rdchk(IRP_A_G0_LO, 8'h79);
    wr(IRP_A_G1_HI, 8'ha5);
    wr(IRP_A_G1_LO, 8'h5a);
    rdchk(IRP_A_G1_HI, 8'ha5);
    rdchk(IRP_A_G1_LO, 8'h5a);
    wr(IRP_A_G2_REQ, 8'h0a);
    rdchk(IRP_A_G2_REQ, 8'h0a);
    foreach (regs[i]) wr(regs[i], 8'h00);
    $display("Test register access done");
  endtask

  task automatic t_portc;
    wr(IRP_A_MASK, 8'h1f);
    g2h <= 4'h4;
    g2l <= 4'h4;
    pc <= 4'h4;
    cyc(5);
    chk({7'h00, irq}, 8'h01, "irq on pin event");
    chk({5'h00, req, lvl}, 8'h00, "no request while disabled");
    rdchk(IRP_A_G2_REQ, 8'h04);
    rdchk(IRP_A_STAT, 8'h04);
    chk({7'h00, irq}, 8'h00, "irq after status read");
    gie <= 1'b1;
    cyc(2);
    chk({5'h00, req, lvl}, 8'h07, "forwarded at high level");
    wr(IRP_A_G2_REQ, 8'h00);
    pc <= 4'h0;
    gie <= 1'b0;
    cyc(3);
    chk({7'h00, req}, 8'h00, "request gone after clear");
    $display("Test port C request done");
  endtask

  // Timer one request walked through all four enable codes
  task automatic t_levels;
    gie <= 1'b1;
    g0p <= 8'h40;
    for (int c = 0; c < 4; c++) begin
      wr(IRP_A_G0_HI, {1'b0, c[1], 6'h00});
      wr(IRP_A_G0_LO, {1'b0, c[0], 6'h00});
      cyc(2);
      chk({5'h00, req, lvl}, {5'h00, c != 0, c[1:0]}, "group 0 level");
    end
    wr(IRP_A_G0_HI, 8'h00);
    wr(IRP_A_G0_LO, 8'h00);
    g0p <= 8'h00;
    gie <= 1'b0;
    $display("Test group 0 levels done");
  endtask

  // Pin 0 falls on falling select, pin 1 needs its rising edge
  task automatic t_porta;
    wr(IRP_A_EDGE, 8'h02);
    pa <= 8'hfe;
    cyc(5);
    pa <= 8'hfc;
    cyc(5);
    chk(g1p, 8'h01, "falling edge only on pin 0");
    pa <= 8'hfe;
    cyc(5);
    chk(g1p, 8'h03, "rising edge on pin 1");
    gie <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(IRP_A_G1_HI, {6'h00, c[1], 1'b0});
      wr(IRP_A_G1_LO, {6'h00, c[0], 1'b0});
      cyc(2);
      chk({5'h00, req, lvl}, {5'h00, c != 0, c[1:0]}, "group 1 level");
    end
    gie <= 1'b0;
    g1_clr <= 1'b1;
    cyc(1);
    g1_clr <= 1'b0;
    $display("Test port A edges done");
  endtask

  // Reset in mid-run: what earlier tests left behind must come back cleared
  task automatic t_midreset;
    wr(IRP_A_G2_REQ, 8'h05);
    wr(IRP_A_EDGE, 8'hff);
    chk({7'h00, irq}, 8'h01, "irq still set from port A events");
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(2);
    chk({4'h0, req, lvl, irq}, 8'h00, "outputs after mid-run reset");
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    rdchk(IRP_A_EDGE, 8'h00);
    rdchk(IRP_A_STAT, 8'h00);
    $display("Test mid-run reset done");
  endtask

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_regs;
    t_portc;
    t_levels;
    t_porta;
    t_midreset;
    report_and_stop;
  end
endmodule
`default_nettype wire
